/* File: common/sdc_defines.svh */
// Purpose: constants for the segment descriptor checker
// Assumes: eight-byte descriptor split into a low and a high doubleword
// Notes:   offsets are byte addresses on the register bus
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SDC_OFS_DESC_LO   12'h000
`define SDC_OFS_DESC_HI   12'h004
`define SDC_OFS_OFFSET    12'h008
`define SDC_OFS_CTRL      12'h00C
`define SDC_OFS_STATUS    12'h010
`define SDC_OFS_BASE      12'h014
`define SDC_OFS_LIMIT     12'h018
`define SDC_OFS_ATTR      12'h01C

// ------------------------------------------------------------
// descriptor field positions, high doubleword
// ------------------------------------------------------------
`define SDC_HI_BASE_MID_LSB   0
`define SDC_HI_TYPE_LSB       8
`define SDC_HI_APP_KIND       12
`define SDC_HI_PRIV_LSB       13
`define SDC_HI_RESIDENT       15
`define SDC_HI_LIMIT_HI_LSB   16
`define SDC_HI_AVAIL          20
`define SDC_HI_NATIVE_WIDE    21
`define SDC_HI_WIDTH          22
`define SDC_HI_UNIT_SCALE     23
`define SDC_HI_BASE_HI_LSB    24

// type field bits
`define SDC_TYPE_ACCESSED     0
`define SDC_TYPE_WRITE_READ   1
`define SDC_TYPE_DIR_CONF     2
`define SDC_TYPE_CODE         3

// ------------------------------------------------------------
// control register bits
// ------------------------------------------------------------
`define SDC_CTRL_IS_STACK     0
`define SDC_CTRL_WIDE_MODE    1
`define SDC_CTRL_PFX_OPSIZE   2
`define SDC_CTRL_PFX_ADSIZE   3
`define SDC_CTRL_LOAD         4
`define SDC_CTRL_CHECK        5

// ------------------------------------------------------------
// limits and reset values
// ------------------------------------------------------------
`define SDC_UPPER_WIDE        32'hFFFF_FFFF
`define SDC_UPPER_NARROW      32'h0000_FFFF
`define SDC_PAGE_FILL         12'hFFF
`define SDC_RESET_WORD        32'h0000_0000

`endif

/* File: common/sdc_pkg.sv */
// Purpose: types for the segment descriptor checker
// Assumes: nothing beyond the defines header
// Notes:   widths follow the descriptor layout
package sdc_pkg;

  typedef enum logic [1:0]
  {
    SDC_W16,
    SDC_W32,
    SDC_W64
  } sdc_width_t;

  typedef enum logic [1:0]
  {
    SDC_SYSTEM,
    SDC_DATA,
    SDC_CODE
  } sdc_class_t;

endpackage : sdc_pkg

/* File: hw/sdc_check.sv */
// Purpose: decode a segment descriptor, check offsets, raise faults
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   descriptor and offset written by software, results read back
//
// What this block does
// - join both limit pieces into one 20-bit limit first
// - unit scale clear: limit counts bytes, sizes up to 1 MByte
// - unit scale set: limit counts 4-KByte units, up to 4 GBytes
// - expand-up accepts 0..limit; beyond faults, stack or general
// - expand-down accepts limit+1..upper bound set by stack width flag
// - join three base pieces into one unscaled 32-bit base
// - app kind flag picks system versus code/data type meaning
// - privilege is two bits, 0..3, 0 most privileged
// - loading a non-resident descriptor raises not-present fault
// - non-resident descriptor: other positions carry no meaning
// - code width bit picks 32-bit or 16-bit defaults
// - prefixes 66H and 67H flip operand and address size
// - stack width flag picks wide or narrow stack pointer
// - with unit scale the low twelve offset bits are not compared
// - native wide code bit picks 64-bit or compatibility mode
// - bit 20 of the high word is ignored
// - type bit 11 separates data from code; low bits qualify
// - stack load of a non-writable data segment raises general fault
`timescale 1ns/1ps
`include "sdc_defines.svh"

module sdc_check
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [11:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   general_protection_fault,
  output logic                   stack_fault,
  output logic                   not_present_fault,
  output sdc_pkg::sdc_width_t    code_mode,
  output logic                   stack_pointer_wide
);
  import sdc_pkg::*;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic [31:0] desc_lo;
  logic [31:0] desc_hi;
  logic [31:0] offset;
  logic [3:0]  ctrl;
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic        load_pulse;
  logic        check_pulse;

  wire         bus_take = hsel && hready && htrans[1];
  wire         wr_fire  = wr_pend;

  // zero wait states: every access is answered in its data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_pend <= 1'b0;
    else
      wr_pend <= bus_take && hwrite;
  end

  // address kept only on a taken transfer, so idle cycles cost no toggles
  sdc_word_reg
  #(
    .WIDTH (12),
    .INIT  (`SDC_RESET_WORD)
  )
  wr_addr_reg
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (bus_take),
    .din     (haddr),
    .q       (wr_addr)
  );

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  // writes land at the end of the data phase
  wire         desc_lo_we = wr_fire && (wr_addr == `SDC_OFS_DESC_LO);
  wire         desc_hi_we = wr_fire && (wr_addr == `SDC_OFS_DESC_HI);
  wire         offset_we  = wr_fire && (wr_addr == `SDC_OFS_OFFSET);
  wire         ctrl_we    = wr_fire && (wr_addr == `SDC_OFS_CTRL);
  wire         next_load  = ctrl_we && hwdata[`SDC_CTRL_LOAD];
  wire         next_check = ctrl_we && hwdata[`SDC_CTRL_CHECK];

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  sdc_word_reg
  #(
    .WIDTH (32),
    .INIT  (`SDC_RESET_WORD)
  )
  desc_lo_reg
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (desc_lo_we),
    .din     (hwdata),
    .q       (desc_lo)
  );

  sdc_word_reg
  #(
    .WIDTH (32),
    .INIT  (`SDC_RESET_WORD)
  )
  desc_hi_reg
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (desc_hi_we),
    .din     (hwdata),
    .q       (desc_hi)
  );

  sdc_word_reg
  #(
    .WIDTH (32),
    .INIT  (`SDC_RESET_WORD)
  )
  offset_reg
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (offset_we),
    .din     (hwdata),
    .q       (offset)
  );

  sdc_word_reg
  #(
    .WIDTH (4),
    .INIT  (`SDC_RESET_WORD)
  )
  ctrl_reg
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (ctrl_we),
    .din     (hwdata[3:0]),
    .q       (ctrl)
  );

  // load and check are one-cycle strobes, never kept in ctrl
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      load_pulse  <= 1'b0;
      check_pulse <= 1'b0;
    end
    else
    begin
      load_pulse  <= next_load;
      check_pulse <= next_check;
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  wire [19:0] raw_limit  = {desc_hi[`SDC_HI_LIMIT_HI_LSB +: 4], desc_lo[15:0]};
  wire [31:0] seg_base   = {desc_hi[`SDC_HI_BASE_HI_LSB +: 8],
                            desc_hi[`SDC_HI_BASE_MID_LSB +: 8], desc_lo[31:16]};
  wire [3:0]  seg_type   = desc_hi[`SDC_HI_TYPE_LSB +: 4];
  wire        app_kind   = desc_hi[`SDC_HI_APP_KIND];
  wire [1:0]  segment_privilege = desc_hi[`SDC_HI_PRIV_LSB +: 2];
  wire        resident   = desc_hi[`SDC_HI_RESIDENT];
  wire        native_wide = desc_hi[`SDC_HI_NATIVE_WIDE];
  wire        width_flag = desc_hi[`SDC_HI_WIDTH];
  wire        unit_scale = desc_hi[`SDC_HI_UNIT_SCALE];
  // bit 20 is never read: free for software

  wire        is_code    = app_kind && seg_type[`SDC_TYPE_CODE];
  wire        is_data    = app_kind && !seg_type[`SDC_TYPE_CODE];
  wire        expand_dn  = is_data && seg_type[`SDC_TYPE_DIR_CONF];
  wire        writable   = is_data && seg_type[`SDC_TYPE_WRITE_READ];
  wire        is_stack   = ctrl[`SDC_CTRL_IS_STACK];
  wire        wide_mode  = ctrl[`SDC_CTRL_WIDE_MODE];

  // ------------------------------------------------------------
  // limit scaling and offset check
  // ------------------------------------------------------------
  // scaled limit fills low twelve bits so they never fail the compare
  wire [31:0] eff_limit  = unit_scale ? {raw_limit, `SDC_PAGE_FILL}
                                      : {12'h000, raw_limit};
  wire [31:0] upper      = width_flag ? `SDC_UPPER_WIDE : `SDC_UPPER_NARROW;
  wire        up_bad     = offset > eff_limit;
  wire        dn_bad     = (offset <= eff_limit) || (offset > upper);
  wire        range_bad  = expand_dn ? dn_bad : up_bad;

  // ------------------------------------------------------------
  // fault and mode outputs
  // ------------------------------------------------------------
  // not-present wins; other fields are meaningless then
  wire        np_hit     = load_pulse && !resident;
  wire        ss_type_bad = load_pulse && resident && is_stack && !writable;
  wire        chk_hit    = check_pulse && resident && range_bad;

  sdc_width_t next_code_mode;
  assign next_code_mode = (wide_mode && native_wide) ? SDC_W64 :
                          width_flag ? SDC_W32 : SDC_W16;

  wire        op_wide    = width_flag ^ ctrl[`SDC_CTRL_PFX_OPSIZE];
  wire        ad_wide    = width_flag ^ ctrl[`SDC_CTRL_PFX_ADSIZE];

  // a range fault is a stack fault only on the stack segment
  wire        next_ss    = chk_hit && is_stack;
  wire        next_gp    = ss_type_bad || (chk_hit && !is_stack);
  wire        code_load  = load_pulse && resident && is_code;
  wire        stack_load = load_pulse && resident && is_stack;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      general_protection_fault <= 1'b0;
      stack_fault              <= 1'b0;
      not_present_fault        <= 1'b0;
    end
    else
    begin
      not_present_fault        <= np_hit;
      stack_fault              <= next_ss;
      general_protection_fault <= next_gp;
    end
  end

  // modes stand until the next qualifying load
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      code_mode <= SDC_W16;
    else if (code_load)
      code_mode <= next_code_mode;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stack_pointer_wide <= 1'b0;
    else if (stack_load)
      stack_pointer_wide <= width_flag;
  end

  // ------------------------------------------------------------
  // status and attribute words
  // ------------------------------------------------------------

  wire [31:0] status_word = {26'h000_0000,
                             stack_pointer_wide,
                             code_mode,
                             not_present_fault,
                             stack_fault,
                             general_protection_fault};
  wire [31:0] attr_word   = {18'h0_0000,
                             ad_wide,
                             op_wide,
                             segment_privilege,
                             app_kind,
                             is_code,
                             expand_dn,
                             writable,
                             seg_type,
                             unit_scale,
                             width_flag};

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // registered at the address phase: a write to the same word
  // in the data phase ending on that edge is not yet seen
  wire        rd_take     = bus_take && !hwrite;
  wire        rd_lo       = (haddr == `SDC_OFS_DESC_LO);
  wire        rd_hi       = (haddr == `SDC_OFS_DESC_HI);
  wire        rd_off      = (haddr == `SDC_OFS_OFFSET);
  wire        rd_ctrl     = (haddr == `SDC_OFS_CTRL);
  wire        rd_stat     = (haddr == `SDC_OFS_STATUS);
  wire        rd_base     = (haddr == `SDC_OFS_BASE);
  wire        rd_lim      = (haddr == `SDC_OFS_LIMIT);
  wire        rd_attr     = (haddr == `SDC_OFS_ATTR);

  wire [31:0] rd_sel      = rd_lo   ? desc_lo :
                            rd_hi   ? desc_hi :
                            rd_off  ? offset :
                            rd_ctrl ? {28'h000_0000, ctrl} :
                            rd_stat ? status_word :
                            rd_base ? seg_base :
                            rd_lim  ? eff_limit :
                            rd_attr ? attr_word : 32'h0000_0000;
  wire [31:0] next_hrdata = rd_take ? rd_sel : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else
      hrdata <= next_hrdata;
  end

endmodule : sdc_check

// ------------------------------------------------------------
// loadable word register, shared by every writable field
// ------------------------------------------------------------
module sdc_word_reg
#(
  parameter int          WIDTH = 32,
  parameter logic [31:0] INIT  = 32'h0000_0000
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] q
);
  // reset value cut to the register's own width
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= INIT[WIDTH-1:0];
    else if (load)
      q <= din;
  end
endmodule : sdc_word_reg

/* File: verif/sdc_check_checker.sv */
// Purpose: bus and fault timing checks
// Assumes: zero wait, ops started by a CTRL write
// Notes:   ops flag is one cycle after the data phase
`timescale 1ns/1ps
`include "sdc_defines.svh"
module sdc_check_checker
(
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [11:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [2:0]         hsize,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               general_protection_fault,
  input wire logic               stack_fault,
  input wire logic               not_present_fault,
  input wire sdc_pkg::sdc_width_t code_mode,
  input wire logic               stack_pointer_wide
);
  import sdc_pkg::*;
  // ----
  // data phase tracking
  // ----
  logic       dph_w, dph_r, ctl, unm, stk;
  logic [1:0] ops;
  wire        take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {dph_w, dph_r, ctl, unm, stk, ops} <= '0;
    else
    begin
      dph_w <= take & hwrite;
      dph_r <= take & !hwrite;
      ctl   <= haddr == `SDC_OFS_CTRL;
      unm   <= haddr[11:5] != 7'h00;
      ops   <= (dph_w & ctl) ? hwdata[5:4] : 2'b00;
      stk   <= hwdata[0];
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_gone(x);
    !x;
  endsequence
  AST_READY: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  AST_IDLE_DATA: assert property (!dph_r |-> hrdata == 32'h0000_0000) else $error("read data outside data phase");
  AST_UNMAPPED: assert property (dph_r && unm |-> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
  AST_GP: assert property (general_protection_fault |-> $past(ops) != 2'b00 ##1 s_gone(general_protection_fault))
    else $error("general fault timing");
  AST_SS: assert property (stack_fault |-> $past(ops[1]) && $past(stk) ##1 s_gone(stack_fault))
    else $error("stack fault timing");
  AST_NP: assert property (not_present_fault |-> $past(ops[0]) ##1 s_gone(not_present_fault))
    else $error("not present fault timing");
  AST_MODE: assert property ($changed(code_mode) |-> ops[0] || $past(ops[0])) else $error("code mode moved");
  AST_SPW: assert property ($changed(stack_pointer_wide) |-> ops[0] || $past(ops[0]))
    else $error("stack width moved");
  AST_MODE_ENC: assert property (code_mode != 2'b11) else $error("code mode out of range");
endmodule : sdc_check_checker
bind sdc_check sdc_check_checker sdc_check_checker_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .general_protection_fault, .stack_fault, .not_present_fault,
  .code_mode, .stack_pointer_wide);

/* File: verif/sdc_master.sv */
// Purpose: bus master standing in for the load logic
// Assumes: one slave, hready is its hreadyout
// Notes:   waits for hready, never counts cycles
`timescale 1ns/1ps
module sdc_master
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    // stale data must not look valid
    hwdata <= ~d;
  endtask : xfer
endmodule : sdc_master

/* File: verif/sdc_check_bench.sv */
// Purpose: directed checks of limits, faults, modes
// Assumes: faults sampled one edge after CTRL lands
// Notes:   data descriptors keep bit 21 clear
`timescale 1ns/1ps
`include "sdc_defines.svh"
module sdc_check_bench;
  import sdc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, gpf, ssf, npf, spw;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  sdc_width_t  cm;
  int          err_total = 0, n_compared = 0, cyc = 0;
  always #20 hclk = ~hclk;
  sdc_master sdc_master_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  sdc_check sdc_check_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .general_protection_fault(gpf), .stack_fault(ssf), .not_present_fault(npf), .code_mode(cm),
    .stack_pointer_wide(spw));
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic [31:0] lo, hi, off, input logic [5:0] c, input logic [2:0] f);
    sdc_master_i.xfer(`SDC_OFS_DESC_LO, 1'b1, lo, q);
    sdc_master_i.xfer(`SDC_OFS_DESC_HI, 1'b1, hi, q);
    sdc_master_i.xfer(`SDC_OFS_OFFSET, 1'b1, off, q);
    sdc_master_i.xfer(`SDC_OFS_CTRL, 1'b1, {26'h000_0000, c}, q);
    @(posedge hclk);
    #1 chk({29'h0000_0000, npf, ssf, gpf}, {29'h0000_0000, f});
  endtask : op
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      summarize();
    end
  end
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    op(32'h0000_1000, 32'h0000_9200, 32'h0000_1000, 6'h20, 3'h0);
    op(32'h0000_1000, 32'h0000_9200, 32'h0000_1001, 6'h20, 3'h1);
    op(32'h0000_1000, 32'h0000_9200, 32'h0000_1001, 6'h21, 3'h2);
    op(32'h0000_0000, 32'h0080_9200, 32'h0000_0FFF, 6'h20, 3'h0);
    op(32'h0000_0000, 32'h0080_9200, 32'h0000_1000, 6'h20, 3'h1);
    op(32'h0000_00FF, 32'h0000_9600, 32'h0000_00FF, 6'h20, 3'h1);
    op(32'h0000_00FF, 32'h0000_9600, 32'h0000_0100, 6'h20, 3'h0);
    op(32'h0000_00FF, 32'h0000_9600, 32'h0001_0000, 6'h20, 3'h1);
    op(32'h0000_00FF, 32'h0040_9600, 32'h0001_0000, 6'h20, 3'h0);
    op(32'h0000_0000, 32'h000F_9200, 32'h000F_0001, 6'h20, 3'h1);
    op(32'h0000_0000, 32'h001F_9200, 32'h000F_0000, 6'h20, 3'h0);
    $display("test limits done");
    op(32'hDEAD_BEEF, 32'h0000_1200, 32'h0000_0000, 6'h10, 3'h4);
    op(32'hDEAD_BEEF, 32'h0000_1200, 32'h0000_0000, 6'h20, 3'h0);
    op(32'h0000_FFFF, 32'h0000_9000, 32'h0000_0000, 6'h11, 3'h1);
    op(32'h0000_FFFF, 32'h0040_9200, 32'h0000_0000, 6'h11, 3'h0);
    chk({31'h0000_0000, spw}, 32'h0000_0001);
    op(32'h0000_FFFF, 32'h0000_9200, 32'h0000_0000, 6'h11, 3'h0);
    chk({31'h0000_0000, spw}, 32'h0000_0000);
    $display("test faults done");
    op(32'h0000_FFFF, 32'h0000_9A00, 32'h0000_0000, 6'h10, 3'h0);
    chk({30'h0000_0000, cm}, {30'h0000_0000, SDC_W16});
    op(32'h0000_FFFF, 32'h0020_9A00, 32'h0000_0000, 6'h12, 3'h0);
    chk({30'h0000_0000, cm}, {30'h0000_0000, SDC_W64});
    for (int k = 0; k < 3; k++)
    begin
      op(32'h0000_FFFF, 32'h0040_9A00, 32'h0000_0000, 6'h10 | 6'(k << 2), 3'h0);
      chk({30'h0000_0000, cm}, {30'h0000_0000, SDC_W32});
      sdc_master_i.xfer(`SDC_OFS_ATTR, 1'b0, 32'h0000_0000, q);
      chk(q & 32'h0000_3000, 32'(3 - k) << 12);
    end
    op(32'h0000_FFFF, 32'h0040_9A00, 32'h0000_0000, 6'h12, 3'h0);
    chk({30'h0000_0000, cm}, {30'h0000_0000, SDC_W32});
    sdc_master_i.xfer(`SDC_OFS_STATUS, 1'b0, 32'h0000_0000, q);
    chk(q, 32'(SDC_W32) << 3);
    sdc_master_i.xfer(`SDC_OFS_CTRL, 1'b0, 32'h0000_0000, q);
    chk(q, 32'h0000_0002);
    $display("test modes done");
    op(32'h5670_0010, 32'h12C0_F234, 32'h0000_0000, 6'h10, 3'h0);
    sdc_master_i.xfer(`SDC_OFS_BASE, 1'b0, 32'h0000_0000, q);
    chk(q, 32'h1234_5670);
    sdc_master_i.xfer(`SDC_OFS_DESC_HI, 1'b0, 32'h0000_0000, q);
    chk(q, 32'h12C0_F234);
    sdc_master_i.xfer(`SDC_OFS_LIMIT, 1'b0, 32'h0000_0000, q);
    chk(q, 32'h0001_0FFF);
    sdc_master_i.xfer(`SDC_OFS_ATTR, 1'b0, 32'h0000_0000, q);
    chk(q & 32'h0000_0FFF, 32'h0000_0E4B);
    sdc_master_i.xfer(12'h040, 1'b0, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    $display("test readback done");
    summarize();
  end
endmodule : sdc_check_bench
